// ### rtl/cob_defines.svh
// constants of the configuration option bank
`ifndef COB_DEFINES_SVH
`define COB_DEFINES_SVH
// register indexes, byte address is four times the index
`define COB_IDX_CFG2   16'h001E
`define COB_IDX_CFG1   16'h001F
`define COB_IDX_WDCLR  16'hFFFF
// second register fields
`define COB_B_IRQ_PIN_PULLUP_OFF   7
`define COB_B_IRQ_PIN_FUNCTION_ON    6
`define COB_B_OSCHI    4
`define COB_B_OSCLO    3
`define COB_B_RESET_PIN_FUNCTION_ON    0
// first register fields
`define COB_B_PERSEL   7
`define COB_B_LVSTOP   6
`define COB_B_LVRSTD   5
`define COB_B_LVPWRD   4
`define COB_B_LV5V     3
`define COB_B_SHORT_STOP_RECOVERY    2
`define COB_B_STOPEN   1
`define COB_B_WDDIS    0
// bits that survive resets other than power-on, and the power-on value
`define COB_KEEP2      8'h01
`define COB_KEEP1      8'h08
`define COB_RST_VAL    8'h00
// timing counts in quad bus clock cycles; the wakeup entries are exponents
`define COB_REC_SHORT  13'd32
`define COB_REC_LONG   13'd4096
`define COB_PIN_CYC    6'd32
`define COB_AWU_SHORT  4'd9
`define COB_AWU_LONG   4'd14
`endif

// ### rtl/cob_pkg.sv
// types of the configuration option bank
package cob_pkg;
  typedef enum logic [1:0] {
    COB_OSC_INT  = 2'b00,
    COB_OSC_EXT  = 2'b01,
    COB_OSC_RC   = 2'b10,
    COB_OSC_XTAL = 2'b11
  } cob_osc_t;
  typedef enum logic [1:0] {
    COB_ST_RUN  = 2'b00,
    COB_ST_STOP = 2'b01,
    COB_ST_REC  = 2'b10
  } cob_state_t;
endpackage

// ### rtl/cob_top.sv
// configuration option bank with watchdog and stop control
//
// Function
// - each configuration register takes one write per reset, reads always allowed
// - registers decode at indexes 0x001E and 0x001F
// - pullup bit one disconnects interrupt pin pullup, zero connects it
// - interrupt function bit one enables interrupt function on pin
// - two-bit field picks internal, external, RC or crystal oscillator
// - reset pin function bit one enables reset function on pin
// - reset pin function bit cleared only by power-on reset
// - period bit picks 2^13-2^4 or 2^18-2^4 cycle watchdog timeout
// - in stop, period bit picks 2^9 or 2^14 wakeup ticks
// - run-in-stop bit keeps powered detector alive in stop; reset clears it
// - undervolt reset off bit suppresses detector resets
// - undervolt power off bit powers the detector down
// - voltage mode bit picks 5 V or 3 V; power-on clears it
// - voltage mode bit survives all non power-on resets
// - short recovery bit leaves stop after 32 cycles, else 4096
// - stop exit caused by detector reset always uses long recovery
// - stop disabled makes stop instruction an illegal opcode
// - watchdog disable bit one stops the watchdog
// - watchdog is 6-bit counter fed by 12-bit prescaler; overflow resets
// - watchdog reset drives reset pin 32 cycles and flags status
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "cob_defines.svh"
module cob_top #(
  parameter int PRE_W  = 12,           // prescaler width
  parameter int WD_W   = 6,            // watchdog counter width
  parameter logic [7:0] VEC_LO = 8'h00 // reset vector low byte, arbitrary
) (
  input  wire logic             clk_i,        // quad bus clock
  input  wire logic             rst_i,        // any chip reset
  input  wire logic             por_i,        // reset is power-on
  input  wire logic             cyc_i,        // wishbone cycle
  input  wire logic             stb_i,        // wishbone strobe
  input  wire logic             we_i,         // wishbone write
  input  wire logic [17:0]      adr_i,        // byte address
  input  wire logic [3:0]       sel_i,        // byte lanes
  input  wire logic [31:0]      dat_i,        // write data
  output logic      [31:0]      dat_o,        // read data
  output logic                  ack_o,        // wishbone ack
  input  wire logic             stop_req_i,   // stop instruction pulse
  input  wire logic             wake_i,       // wakeup interrupt pulse
  input  wire logic             lvd_trip_i,   // detector trip, async
  output logic                  irq_pull_en_o,// interrupt pin pullup on
  output logic                  irq_func_o,   // interrupt pin function on
  output cob_pkg::cob_osc_t     osc_sel_o,    // clock source
  output logic                  rst_func_o,   // reset pin function on
  output logic                  lvd_pwr_o,    // detector powered
  output logic                  lvd_5v_o,     // detector 5 V mode
  output logic                  lvd_rst_o,    // detector reset request
  output logic [3:0]            awu_exp_o,    // wakeup period exponent
  output logic                  illegal_op_o, // stop was illegal
  output logic                  stop_o,       // clocks stopped
  output logic                  cpu_run_o,    // cpu may run
  output logic                  wd_rst_o,     // watchdog reset pulse
  output logic                  wd_flag_o,    // status flag set pulse
  output logic                  rst_pin_o,    // reset pin drive value
  output logic                  rst_pin_oe_o  // reset pin pulled low
);
  import cob_pkg::*;

  // elaboration-time guard: the clear field needs prescaler bit 4
  if (PRE_W < 5 || WD_W < 2) begin : g_bad_width
    $error("cob_top: widths too small");
  end

  // ==========================================================
  // register bus
  // ==========================================================
  logic [7:0]  cfg1_q, cfg2_q;
  logic        wr1_q, wr2_q;
  logic        ack_q;
  logic [31:0] dat_q;
  wire  [15:0] idx    = adr_i[17:2];
  wire         req    = cyc_i & stb_i;
  wire         hit1   = idx == `COB_IDX_CFG1;
  wire         hit2   = idx == `COB_IDX_CFG2;
  wire         hitwd  = idx == `COB_IDX_WDCLR;
  wire         wcommit = req & we_i & ack_q & sel_i[0];
  wire         wr1    = wcommit & hit1 & ~wr1_q;
  wire         wr2    = wcommit & hit2 & ~wr2_q;
  wire         wd_clr = wcommit & hitwd;
  wire  [7:0]  rd_b   = hit1 ? cfg1_q : hit2 ? cfg2_q : hitwd ? VEC_LO : 8'h00;

  // one wait state; read data lands on the edge that raises ack, the write on the edge that drops it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) dat_q <= {24'h0, rd_b};
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ==========================================================
  // configuration registers
  // ==========================================================
  // non power-on resets keep the strap-like bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr1_q  <= 1'b0;
      wr2_q  <= 1'b0;
      cfg1_q <= por_i ? `COB_RST_VAL : (cfg1_q & `COB_KEEP1);
      cfg2_q <= por_i ? `COB_RST_VAL : (cfg2_q & `COB_KEEP2);
    end else begin
      if (wr1) begin
        cfg1_q <= dat_i[7:0];
        wr1_q  <= 1'b1;
      end
      if (wr2) begin
        cfg2_q <= dat_i[7:0];
        wr2_q  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // option decode
  // ==========================================================
  cob_state_t st_q;
  logic       trip_m_q, trip_q;
  wire in_stop = st_q == COB_ST_STOP;
  assign irq_pull_en_o = ~cfg2_q[`COB_B_IRQ_PIN_PULLUP_OFF];
  assign irq_func_o    = cfg2_q[`COB_B_IRQ_PIN_FUNCTION_ON];
  assign osc_sel_o     = cob_osc_t'(cfg2_q[`COB_B_OSCHI:`COB_B_OSCLO]);
  assign rst_func_o    = cfg2_q[`COB_B_RESET_PIN_FUNCTION_ON];
  assign lvd_5v_o      = cfg1_q[`COB_B_LV5V];
  // detector sleeps in stop unless asked to stay up
  assign lvd_pwr_o = ~cfg1_q[`COB_B_LVPWRD]
                   & (~in_stop | cfg1_q[`COB_B_LVSTOP]);
  assign lvd_rst_o = trip_q & lvd_pwr_o & ~cfg1_q[`COB_B_LVRSTD];
  assign awu_exp_o = cfg1_q[`COB_B_PERSEL] ? `COB_AWU_SHORT : `COB_AWU_LONG;

  // trip comes from the analog side, so two flops first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_m_q <= 1'b0;
      trip_q   <= 1'b0;
    end else begin
      trip_m_q <= lvd_trip_i;
      trip_q   <= trip_m_q;
    end
  end

  // ==========================================================
  // stop control
  // ==========================================================
  logic [12:0] rec_q;
  logic        ill_q;
  wire stop_ok = stop_req_i & cfg1_q[`COB_B_STOPEN];
  // a detector reset forces the long recovery
  wire [12:0] rec_len = (lvd_rst_o | ~cfg1_q[`COB_B_SHORT_STOP_RECOVERY])
                      ? `COB_REC_LONG : `COB_REC_SHORT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= COB_ST_RUN;
      rec_q <= 13'd0;
      ill_q <= 1'b0;
    end else begin
      ill_q <= stop_req_i & ~cfg1_q[`COB_B_STOPEN];
      unique case (st_q)
        COB_ST_RUN: begin
          if (stop_ok) st_q <= COB_ST_STOP;
        end
        COB_ST_STOP: begin
          if (wake_i | lvd_rst_o) begin
            st_q  <= COB_ST_REC;
            rec_q <= rec_len - 13'd1;
          end
        end
        COB_ST_REC: begin
          if (rec_q == 13'd0) st_q <= COB_ST_RUN;
          else rec_q <= rec_q - 13'd1;
        end
        default: st_q <= COB_ST_RUN;
      endcase
    end
  end
  assign illegal_op_o = ill_q;
  assign stop_o       = st_q != COB_ST_RUN;
  assign cpu_run_o    = st_q == COB_ST_RUN;

  // ==========================================================
  // watchdog
  // ==========================================================
  logic [PRE_W-1:0] pre_q;
  logic [WD_W-1:0]  wd_q;
  logic             wdr_q;
  logic [5:0]       pin_q;
  wire wd_on  = ~cfg1_q[`COB_B_WDDIS] & cpu_run_o;
  wire pre_w  = &pre_q;
  // short period is two prescaler wraps, long is the full counter
  wire wd_ovf = wd_on & pre_w & (cfg1_q[`COB_B_PERSEL] ? wd_q[0] : &wd_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
      wd_q  <= '0;
      wdr_q <= 1'b0;
    end else begin
      wdr_q <= wd_ovf;
      if (stop_ok) begin
        pre_q <= '0;
      end else if (wd_clr) begin
        pre_q[PRE_W-1:4] <= '0;
        wd_q             <= '0;
      end else if (wd_on) begin
        pre_q <= pre_q + 1'b1;
        if (pre_w) wd_q <= wd_q + 1'b1;
      end
    end
  end
  assign wd_rst_o  = wdr_q;
  assign wd_flag_o = wdr_q;

  // pin drive must outlive the reset it causes, so power-on only
  always_ff @(posedge clk_i) begin
    if (rst_i & por_i) pin_q <= 6'd0;
    else if (wdr_q & rst_func_o) pin_q <= `COB_PIN_CYC;
    else if (pin_q != 6'd0) pin_q <= pin_q - 6'd1;
  end
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe_o = pin_q != 6'd0;

  // ==========================================================
  // checks
  // ==========================================================
  int unsigned pin_cnt;
  // of the resets only power-on clears the count, like the pin counter it shadows; an undriven pin clears it too
  always_ff @(posedge clk_i) begin
    if ((rst_i & por_i) | ~rst_pin_oe_o) pin_cnt <= 0;
    else pin_cnt <= pin_cnt + 1;
  end

  // recovery length and exit cause, kept apart from the down counter
  logic [12:0] rec_cnt_q;
  logic        lvx_q;
  always_ff @(posedge clk_i) begin
    if (rst_i | (st_q != COB_ST_REC)) rec_cnt_q <= 13'd0;
    else rec_cnt_q <= rec_cnt_q + 13'd1;
  end
  // a detector exit is remembered until the next stop
  always_ff @(posedge clk_i) begin
    if (rst_i) lvx_q <= 1'b0;
    else if (in_stop) lvx_q <= lvd_rst_o;
  end

  property p_once1;
    @(posedge clk_i) disable iff (rst_i) $past(wr1_q) |-> cfg1_q == $past(cfg1_q);
  endproperty
  a_once1: assert property (p_once1) else $error("cfg1 rewritten");

  property p_once2;
    @(posedge clk_i) disable iff (rst_i) wr2_q & $past(wr2_q) |=> $stable(cfg2_q);
  endproperty
  a_once2: assert property (p_once2) else $error("cfg2 rewritten");

  property p_keep;
    @(posedge clk_i) rst_i & ~por_i |=> cfg1_q[`COB_B_LV5V] == $past(cfg1_q[`COB_B_LV5V])
      && cfg2_q[`COB_B_RESET_PIN_FUNCTION_ON] == $past(cfg2_q[`COB_B_RESET_PIN_FUNCTION_ON]) && !cfg1_q[`COB_B_LVSTOP];
  endproperty
  a_keep: assert property (p_keep) else $error("reset kept wrong bits");

  property p_ill;
    @(posedge clk_i) disable iff (rst_i)
      stop_req_i & !cfg1_q[`COB_B_STOPEN] & cpu_run_o |=> illegal_op_o && cpu_run_o;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal stop missed");

  property p_short;
    @(posedge clk_i) disable iff (rst_i)
      in_stop & wake_i & !lvd_rst_o & cfg1_q[`COB_B_SHORT_STOP_RECOVERY]
      |=> !cpu_run_o ##31 !cpu_run_o ##1 cpu_run_o;
  endproperty
  a_short: assert property (p_short) else $error("short recovery length");

  property p_long;
    @(posedge clk_i) disable iff (rst_i)
      in_stop & lvd_rst_o |=> !cpu_run_o ##32 !cpu_run_o;
  endproperty
  a_long: assert property (p_long) else $error("detector exit not long");

  property p_pin;
    @(posedge clk_i) disable iff (rst_i) rst_pin_oe_o |-> pin_cnt < 32;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin held too long");

  property p_pinst;
    @(posedge clk_i) disable iff (rst_i & por_i)
      wd_rst_o & rst_func_o |=> rst_pin_oe_o [*8];
  endproperty
  a_pinst: assert property (p_pinst) else $error("reset pin not driven");

  property p_wddis;
    @(posedge clk_i) disable iff (rst_i) cfg1_q[`COB_B_WDDIS] |=> !wd_rst_o;
  endproperty
  a_wddis: assert property (p_wddis) else $error("disabled watchdog fired");

  property p_lvr;
    @(posedge clk_i) disable iff (rst_i)
      cfg1_q[`COB_B_LVRSTD] | cfg1_q[`COB_B_LVPWRD] |-> !lvd_rst_o;
  endproperty
  a_lvr: assert property (p_lvr) else $error("detector reset leaked");

  property p_clr;
    @(posedge clk_i) disable iff (rst_i) wd_clr & !stop_ok |=> wd_q == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("watchdog not cleared");

  // exact recovery lengths; a reset in the last cycle is not an exit
  property p_recsh;
    @(posedge clk_i) disable iff (rst_i)
      $fell(stop_o) && !$past(rst_i) && !lvx_q && cfg1_q[`COB_B_SHORT_STOP_RECOVERY]
      |-> rec_cnt_q == `COB_REC_SHORT;
  endproperty
  a_recsh: assert property (p_recsh) else $error("short recovery count wrong");

  property p_reclg;
    @(posedge clk_i) disable iff (rst_i)
      $fell(stop_o) && !$past(rst_i) && (lvx_q || !cfg1_q[`COB_B_SHORT_STOP_RECOVERY])
      |-> rec_cnt_q == `COB_REC_LONG;
  endproperty
  a_reclg: assert property (p_reclg) else $error("long recovery count wrong");

  property p_pinlen;
    @(posedge clk_i) disable iff (rst_i)
      $fell(rst_pin_oe_o) && !$past(rst_i) |-> pin_cnt == `COB_PIN_CYC;
  endproperty
  a_pinlen: assert property (p_pinlen) else $error("reset pin pulse length");

  // bus answers every request after one wait state
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) req & !ack_o |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");

  property p_ackone;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ackone: assert property (p_ackone) else $error("ack held too long");

  property p_rd;
    @(posedge clk_i) disable iff (rst_i)
      req & !we_i & hit1 & !ack_o |=> dat_o[7:0] == $past(cfg1_q) && dat_o[31:8] == '0;
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");

  property p_sel0;
    @(posedge clk_i) disable iff (rst_i)
      req & we_i & ack_o & !sel_i[0] |=> $stable(cfg1_q) && $stable(cfg2_q);
  endproperty
  a_sel0: assert property (p_sel0) else $error("masked write landed");

  property p_stoppwr;
    @(posedge clk_i) disable iff (rst_i) in_stop & !cfg1_q[`COB_B_LVSTOP] |-> !lvd_pwr_o;
  endproperty
  a_stoppwr: assert property (p_stoppwr) else $error("detector awake in stop");

  property p_por;
    @(posedge clk_i) rst_i & por_i |=> cfg1_q == `COB_RST_VAL && cfg2_q == `COB_RST_VAL;
  endproperty
  a_por: assert property (p_por) else $error("power-on left bits set");

  c_stop: cover property (@(posedge clk_i) in_stop ##[1:20] cpu_run_o);
  c_wdr:  cover property (@(posedge clk_i) wd_rst_o);
  c_wr:   cover property (@(posedge clk_i) wr1 ##[1:20] wcommit & hit1);
  c_ill:  cover property (@(posedge clk_i) illegal_op_o);
  c_lvx:  cover property (@(posedge clk_i) in_stop & lvd_rst_o);
endmodule

// ### verif/cob_top_tb.sv
// self-checking testbench of the configuration option bank
`timescale 1ns/10ps
module cob_top_tb;
  import cob_pkg::*;
  // ==========================================================
  // signals and table
  typedef struct {
    logic [17:0] a;
    logic        w;
    logic [3:0]  s;
    logic [7:0]  d;
    logic [7:0]  e;
  } cob_row_t;
  logic        clk_i, rst_i, por_i, cyc_i, stb_i, we_i;
  logic        stop_req_i, wake_i, lvd_trip_i;
  logic [17:0] adr_i;
  logic [3:0]  sel_i, awu_exp_o;
  logic [31:0] dat_i, dat_o, r;
  logic        ack_o, irq_pull_en_o, irq_func_o, rst_func_o, lvd_pwr_o, lvd_5v_o;
  logic        lvd_rst_o, illegal_op_o, stop_o, cpu_run_o, wd_rst_o, wd_flag_o;
  logic        rst_pin_o, rst_pin_oe_o;
  cob_osc_t    osc_sel_o;
  int          mismatches, check_count, n;
  // reads after a write check the write-once latch; sel low does not use it up
  cob_row_t rows [14] = '{
    '{18'h00078, 1'b0, 4'hF, 8'h00, 8'h00}, '{18'h0007C, 1'b0, 4'hF, 8'h00, 8'h00},
    '{18'h00078, 1'b1, 4'hF, 8'h99, 8'h00}, '{18'h00078, 1'b0, 4'hF, 8'h00, 8'h99},
    '{18'h00078, 1'b1, 4'hF, 8'h42, 8'h00}, '{18'h00078, 1'b0, 4'hF, 8'h00, 8'h99},
    '{18'h0007C, 1'b1, 4'h0, 8'hFF, 8'h00}, '{18'h0007C, 1'b0, 4'hF, 8'h00, 8'h00},
    '{18'h0007C, 1'b1, 4'hF, 8'h8E, 8'h00}, '{18'h0007C, 1'b0, 4'hF, 8'h00, 8'h8E},
    '{18'h0007C, 1'b1, 4'hF, 8'h01, 8'h00}, '{18'h0007C, 1'b0, 4'hF, 8'h00, 8'h8E},
    '{18'h00100, 1'b0, 4'hF, 8'h00, 8'h00}, '{18'h3FFFC, 1'b0, 4'hF, 8'h00, 8'h5A}};

  // short prescaler keeps watchdog runs to a few hundred cycles
  cob_top #(.PRE_W(5), .WD_W(3), .VEC_LO(8'h5A)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .stop_req_i(stop_req_i), .wake_i(wake_i), .lvd_trip_i(lvd_trip_i),
    .irq_pull_en_o(irq_pull_en_o), .irq_func_o(irq_func_o), .osc_sel_o(osc_sel_o),
    .rst_func_o(rst_func_o), .lvd_pwr_o(lvd_pwr_o), .lvd_5v_o(lvd_5v_o),
    .lvd_rst_o(lvd_rst_o), .awu_exp_o(awu_exp_o), .illegal_op_o(illegal_op_o),
    .stop_o(stop_o), .cpu_run_o(cpu_run_o), .wd_rst_o(wd_rst_o), .wd_flag_o(wd_flag_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // all helpers start and end just after a rising edge
  task automatic bus(input logic [17:0] a, input logic w, input logic [3:0] s,
                     input logic [7:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    check(k < 20, 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: sig = cpu_run_o;
      1: sig = wd_rst_o;
      default: sig = lvd_rst_o;
    endcase
  endfunction
  // counts edges until the chosen output is seen high, bounded by lim
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sig(k) !== 1'b1 && n < lim);
  endtask
  task automatic pulse(input logic wk);
    if (wk) wake_i <= 1'b1;
    else stop_req_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    stop_req_i <= 1'b0;
  endtask
  task automatic reset(input logic p);
    rst_i <= 1'b1;
    por_i <= p;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end

  // ==========================================================
  // main sequence
  initial begin
    {cyc_i, stb_i, we_i, stop_req_i, wake_i, lvd_trip_i} = '0;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    rst_i = 1'b1;
    por_i = 1'b1;
    // every clock source code, interrupt pin bits flipped per pass, reset pin bit set in the last two passes
    for (int i = 0; i < 4; i++) begin
      reset(1'b1);
      bus(18'h00078, 1'b1, 4'hF, {i[0], !i[0], 1'b0, i[1:0], 2'b00, i[1]});
      bus(18'h0007C, 1'b1, 4'hF, {3'b000, i[0], 4'b0001});
      check(lvd_pwr_o, !i[0]);
      check(osc_sel_o, i[1:0]);
      check(irq_pull_en_o, !i[0]);
      check(irq_func_o, !i[0]);
      check(rst_func_o, i[1]);
    end
    reset(1'b1);
    foreach (rows[j]) begin
      bus(rows[j].a, rows[j].w, rows[j].s, rows[j].d);
      if (!rows[j].w) check(r, {24'h000000, rows[j].e});
    end
    check(lvd_5v_o, 1'b1);
    check(awu_exp_o, 4'h9);
    check(lvd_pwr_o, 1'b1);
    // short period from a clear, then the pin pulse
    bus(18'h3FFFC, 1'b1, 4'hF, 8'h00);
    wait_hi(1, 200);
    check(n >= 48 && n <= 70, 1'b1);
    check(wd_flag_o, 1'b1);
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      if (rst_pin_oe_o === 1'b1) n++;
    end
    check(n, 32);
    check(rst_pin_o, 1'b0);
    bus(18'h3FFFC, 1'b1, 4'hF, 8'h00);
    pulse(1'b0);
    @(posedge clk_i);
    check(stop_o, 1'b1);
    check(lvd_pwr_o, 1'b0);
    pulse(1'b1);
    wait_hi(0, 100);
    check(n >= 32 && n <= 35, 1'b1);
    // warm reset keeps only the power-on-only bits
    reset(1'b0);
    bus(18'h00078, 1'b0, 4'hF, 8'h00);
    check(r, 32'h00000001);
    bus(18'h0007C, 1'b0, 4'hF, 8'h00);
    check(r, 32'h00000008);
    bus(18'h0007C, 1'b1, 4'hF, 8'h21);
    check(awu_exp_o, 4'hE);
    lvd_trip_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(lvd_rst_o, 1'b0);
    lvd_trip_i <= 1'b0;
    pulse(1'b0);
    @(posedge clk_i);
    check(illegal_op_o, 1'b1);
    check(stop_o, 1'b0);
    wait_hi(1, 300);
    check(n, 300);
    // detector trip in stop forces the long recovery
    reset(1'b1);
    bus(18'h0007C, 1'b0, 4'hF, 8'h00);
    check(r, 32'h00000000);
    bus(18'h0007C, 1'b1, 4'hF, 8'h46);
    pulse(1'b0);
    @(posedge clk_i);
    check(lvd_pwr_o, 1'b1);
    lvd_trip_i <= 1'b1;
    wait_hi(2, 10);
    check(n < 10, 1'b1);
    lvd_trip_i <= 1'b0;
    wait_hi(0, 5000);
    check(n >= 4088 && n <= 4100, 1'b1);
    // long period from a clear after the recovery
    bus(18'h3FFFC, 1'b1, 4'hF, 8'h00);
    wait_hi(1, 400);
    check(n >= 236 && n <= 260, 1'b1);
    end_sim;
  end
endmodule
